// >>> core/mmd_pkg.sv
`default_nettype none
package mmd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam logic [19:0] PER_FIRST = 20'h00000;
  localparam logic [19:0] PER_LAST = 20'h0003f;
  localparam logic [19:0] RAM_FIRST = 20'h00040;
  localparam logic [19:0] RAM_LAST = 20'h0023f;
  localparam logic [19:0] BANK_FIRST = 20'h00040;
  localparam logic [19:0] BANK_LAST = 20'h000bf;
  localparam logic [19:0] PROG_LOW_LAST = 20'h00fff;
  localparam int RAM_BYTES = 512;
  localparam int RAM_IDX_W = 9;
  localparam int BANK_COUNT = 16;
  localparam int BANK_REGS = 8;
  localparam int PER_ADDR_W = 6;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT = 2'b01,
    ST_PER = 2'b10
  } mmd_state_t;
endpackage
`default_nettype wire

// >>> core/mmd_memory_map_decoder.sv
`default_nettype none
// Operation
// R01 - decode a one-megabyte space with 20-bit code and data addresses
// R02 - three regions: program, data RAM, memory-mapped peripheral registers
// R03 - sixteen register banks alias the lowest 128 bytes of internal RAM
// R04 - fetches from 00000-00FFF hex are never served
// R05 - no internal program memory; every fetch is an external read (the code refuses fetches at 00000-00FFF hex with cpuFault, no bus cycle)
// R06 - system supplies external program memory answering fetch reads
// R07 - data may target the whole space; internal RAM served on chip
// R08 - 512 bytes of on-chip static RAM, readable and writable
// R09 - register banks sit at 00040-000BF hex, first 128 RAM bytes
// R10 - RAM is not cleared at power-up; software initialises it
// R11 - data outside peripheral space and RAM goes to the external bus
module mmd_memory_map_decoder
  import mmd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // cpu request
  input wire logic cpuReq,
  input wire logic cpuFetch,
  input wire logic cpuWrite,
  input wire logic cpuBank,
  input wire logic [3:0] cpuBankSel,
  input wire logic [2:0] cpuRegSel,
  input wire logic [mmd_pkg::ADDR_W-1:0] cpuAddr,
  input wire logic [mmd_pkg::DATA_W-1:0] cpuWdata,
  // cpu answer
  output logic cpuReady,
  output logic cpuAck,
  output logic cpuFault,
  output logic [mmd_pkg::DATA_W-1:0] cpuRdata,
  // external memory bus
  output logic extReq,
  output logic extWrite,
  output logic extFetch,
  output logic [mmd_pkg::ADDR_W-1:0] extAddr,
  output logic [mmd_pkg::DATA_W-1:0] extWdata,
  input wire logic extAck,
  input wire logic [mmd_pkg::DATA_W-1:0] extRdata,
  // peripheral register space
  output logic perReq,
  output logic perWrite,
  output logic [mmd_pkg::PER_ADDR_W-1:0] perAddr,
  output logic [mmd_pkg::DATA_W-1:0] perWdata,
  input wire logic perAck,
  input wire logic [mmd_pkg::DATA_W-1:0] perRdata
);
  import mmd_pkg::*;

  logic rstSync1, rstSync2;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  wire logic rstnInt = rstSync2;

  // no reset on the array: contents are left as power-up garbage
  logic [DATA_W-1:0] ram [RAM_BYTES]; // R10

  mmd_state_t state, next_state;
  logic [ADDR_W-1:0] effAddr;
  logic [RAM_IDX_W-1:0] ramIdx;
  logic inPer, inRam, lowFetch, ramWe, idleReq;
  logic next_cpuReady, next_cpuAck, next_cpuFault;
  logic [DATA_W-1:0] next_cpuRdata;
  logic next_extReq, next_extWrite, next_extFetch;
  logic [ADDR_W-1:0] next_extAddr;
  logic [DATA_W-1:0] next_extWdata;
  logic next_perReq, next_perWrite;
  logic [PER_ADDR_W-1:0] next_perAddr;
  logic [DATA_W-1:0] next_perWdata;

  // bank access is just another view of the low RAM bytes
  always_comb begin
    if (cpuBank) begin
      effAddr = BANK_FIRST + {13'h0000, cpuBankSel, cpuRegSel}; // R03 R09
    end else begin
      effAddr = cpuAddr; // R01
    end
    inPer = (effAddr <= PER_LAST); // R02
    inRam = (effAddr >= RAM_FIRST) && (effAddr <= RAM_LAST); // R08
    lowFetch = cpuFetch && (effAddr <= PROG_LOW_LAST); // R04
    ramIdx = RAM_IDX_W'(effAddr - RAM_FIRST);
    idleReq = cpuReq && (state == ST_IDLE);
  end

  always_comb begin
    next_state = state;
    next_cpuReady = cpuReady;
    next_cpuAck = 1'b0;
    next_cpuFault = 1'b0;
    next_cpuRdata = cpuRdata;
    next_extReq = extReq;
    next_extWrite = extWrite;
    next_extFetch = extFetch;
    next_extAddr = extAddr;
    next_extWdata = extWdata;
    next_perReq = perReq;
    next_perWrite = perWrite;
    next_perAddr = perAddr;
    next_perWdata = perWdata;
    ramWe = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_cpuReady = 1'b1;
        if (idleReq) begin
          if (lowFetch) begin
            // refused without touching the bus
            next_cpuAck = 1'b1; // R04
            next_cpuFault = 1'b1; // R04
            next_cpuRdata = '0;
          end else if (cpuFetch) begin
            next_state = ST_EXT; // R05 R06
            next_cpuReady = 1'b0;
            next_extReq = 1'b1;
            next_extWrite = 1'b0;
            next_extFetch = 1'b1;
            next_extAddr = effAddr;
          end else if (inPer) begin
            next_state = ST_PER; // R02
            next_cpuReady = 1'b0;
            next_perReq = 1'b1;
            next_perWrite = cpuWrite;
            next_perAddr = PER_ADDR_W'(effAddr);
            next_perWdata = cpuWdata;
          end else if (inRam) begin
            next_cpuAck = 1'b1; // R07 R08
            ramWe = cpuWrite;
            next_cpuRdata = cpuWrite ? cpuWdata : ram[ramIdx];
          end else begin
            next_state = ST_EXT; // R11
            next_cpuReady = 1'b0;
            next_extReq = 1'b1;
            next_extWrite = cpuWrite;
            next_extFetch = 1'b0;
            next_extAddr = effAddr;
            next_extWdata = cpuWdata;
          end
        end
      end
      ST_EXT: begin
        // slow memories: hold the cycle until the far side answers
        if (extAck) begin
          next_state = ST_IDLE;
          next_cpuReady = 1'b1;
          next_cpuAck = 1'b1;
          next_cpuRdata = extWrite ? extWdata : extRdata;
          next_extReq = 1'b0;
        end
      end
      ST_PER: begin
        if (perAck) begin
          next_state = ST_IDLE;
          next_cpuReady = 1'b1;
          next_cpuAck = 1'b1;
          next_cpuRdata = perWrite ? perWdata : perRdata;
          next_perReq = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cpuReady = 1'b1;
        next_extReq = 1'b0;
        next_perReq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (ramWe) begin
      ram[ramIdx] <= cpuWdata; // R03 R08
    end
  end

  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      state <= ST_IDLE;
      cpuReady <= 1'b0;
      cpuAck <= 1'b0;
      cpuFault <= 1'b0;
      cpuRdata <= 8'h00;
      extReq <= 1'b0;
      extWrite <= 1'b0;
      extFetch <= 1'b0;
      extAddr <= 20'h00000;
      extWdata <= 8'h00;
      perReq <= 1'b0;
      perWrite <= 1'b0;
      perAddr <= 6'h00;
      perWdata <= 8'h00;
    end else begin
      state <= next_state;
      cpuReady <= next_cpuReady;
      cpuAck <= next_cpuAck;
      cpuFault <= next_cpuFault;
      cpuRdata <= next_cpuRdata;
      extReq <= next_extReq;
      extWrite <= next_extWrite;
      extFetch <= next_extFetch;
      extAddr <= next_extAddr;
      extWdata <= next_extWdata;
      perReq <= next_perReq;
      perWrite <= next_perWrite;
      perAddr <= next_perAddr;
      perWdata <= next_perWdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstnInt);

  chk_low_fetch_fault: assert property ( // R04
    idleReq && lowFetch |=> cpuAck && cpuFault && !extReq)
    else $error("low fetch not refused");
  chk_fetch_goes_ext: assert property ( // R05
    idleReq && cpuFetch && !lowFetch |=>
      extReq && extFetch && !extWrite && extAddr == $past(effAddr))
    else $error("fetch not sent to external bus");
  chk_data_goes_ext: assert property ( // R11
    idleReq && !cpuFetch && !inPer && !inRam |=>
      extReq && !extFetch && extWrite == $past(cpuWrite))
    else $error("outside data not sent external");
  chk_ram_local: assert property ( // R08
    idleReq && !cpuFetch && inRam |=> cpuAck && !extReq && !perReq)
    else $error("ram access not served on chip");
  chk_per_route: assert property ( // R02
    idleReq && !cpuFetch && inPer |=>
      perReq && perAddr == $past(effAddr[PER_ADDR_W-1:0]))
    else $error("peripheral access misrouted");
  chk_bank_range: assert property ( // R09
    cpuBank |-> effAddr >= BANK_FIRST && effAddr <= BANK_LAST && inRam)
    else $error("bank address outside bank window");
  chk_bank_alias: assert property ( // R03
    idleReq && cpuBank && cpuWrite && !cpuFetch ##1
      idleReq && !cpuBank && !cpuWrite && !cpuFetch &&
      effAddr == $past(effAddr) |=> cpuRdata == $past(cpuWdata, 2))
    else $error("bank write not seen as ram byte");
  chk_ext_hold: assert property ( // R07
    extReq && !extAck |=> extReq && $stable(extAddr) && !cpuAck)
    else $error("external cycle dropped early");

  cov_fetch_ext: cover property (
    idleReq && cpuFetch ##1 extReq ##[1:10] cpuAck);
  cov_low_fault: cover property (cpuFault);
  cov_ram_read: cover property (idleReq && inRam && !cpuWrite ##1 cpuAck);
  cov_per_done: cover property (perReq && perAck);
endmodule
`default_nettype wire

// >>> testbench/mmd_mem_model.sv
`default_nettype none
module mmd_mem_model (
  // bus clock
  input wire logic clk_sys,
  // request side
  input wire logic req,
  input wire logic write,
  input wire logic fetch,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] waitCycles,
  // answer side
  output var logic ack,
  output var logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [19:0]];
  logic [2:0] cnt;
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h5};
  endfunction
  initial begin
    ack = 1'b0;
    rdata = 8'h00;
    cnt = 3'h0;
  end
  // answers after waitCycles, prompt when zero
  always @(posedge clk_sys) begin
    if (req && !ack && cnt >= waitCycles) begin
      ack <= 1'b1;
      cnt <= 3'h0;
      if (write && !fetch) mem[addr] = wdata;
      rdata <= mem.exists(addr) ? mem[addr] : pat(addr);
    end else begin
      ack <= 1'b0;
      // released data lines must not look like a held value
      rdata <= ~rdata;
      cnt <= (req && !ack) ? cnt + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/mmd_memory_map_decoder_tb.sv
`default_nettype none
module mmd_memory_map_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mmd_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cpuReq = 0, cpuFetch = 0, cpuWrite = 0, cpuBank = 0;
  logic [3:0] cpuBankSel = 0;
  logic [2:0] cpuRegSel = 0, extWait = 0, perWait = 0;
  logic [ADDR_W-1:0] cpuAddr = 0, extAddr;
  logic [DATA_W-1:0] cpuWdata = 0, cpuRdata, extWdata, extRdata;
  logic [DATA_W-1:0] perWdata, perRdata;
  logic cpuReady, cpuAck, cpuFault, extReq, extWrite, extFetch, extAck;
  logic perReq, perWrite, perAck;
  logic [PER_ADDR_W-1:0] perAddr;
  logic [7:0] shadow [logic [19:0]];
  int errors = 0, nTests = 0, seed = 25;
  always #4 clk_sys = ~clk_sys;
  mmd_memory_map_decoder i_dut (.clk_sys, .rstn, .cpuReq, .cpuFetch,
    .cpuWrite, .cpuBank, .cpuBankSel, .cpuRegSel, .cpuAddr, .cpuWdata,
    .cpuReady, .cpuAck, .cpuFault, .cpuRdata, .extReq, .extWrite,
    .extFetch, .extAddr, .extWdata, .extAck, .extRdata, .perReq,
    .perWrite, .perAddr, .perWdata, .perAck, .perRdata);
  mmd_mem_model i_ext (.clk_sys(clk_sys), .req(extReq), .write(extWrite),
    .fetch(extFetch), .addr(extAddr), .wdata(extWdata),
    .waitCycles(extWait), .ack(extAck), .rdata(extRdata));
  mmd_mem_model i_per (.clk_sys(clk_sys), .req(perReq), .write(perWrite),
    .fetch(1'b0), .addr({14'h0, perAddr}), .wdata(perWdata),
    .waitCycles(perWait), .ack(perAck), .rdata(perRdata));
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h5};
  endfunction
  task report_and_stop;
    $display("tests %0d errors %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task op(input logic f, w, b, input logic [3:0] bs,
      input logic [2:0] rs, input logic [19:0] a, input logic [7:0] wd);
    int n;
    logic [19:0] ea;
    logic [7:0] ex;
    logic refused;
    ea = b ? 20'h40 + {13'h0, bs, rs} : a;
    refused = f && ea <= PROG_LOW_LAST;
    if (refused) ex = 8'h00;
    else if (w && !f) begin
      ex = wd;
      shadow[ea] = wd;
    end else ex = shadow.exists(ea) ? shadow[ea] : pat(ea);
    @(negedge clk_sys);
    extWait = 3'($random(seed));
    perWait = 3'($random(seed));
    n = 0;
    while (cpuReady !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    {cpuReq, cpuFetch, cpuWrite, cpuBank} = {1'b1, f, w, b};
    {cpuBankSel, cpuRegSel, cpuAddr, cpuWdata} = {bs, rs, a, wd};
    @(negedge clk_sys);
    cpuReq = 1'b0;
    n = 0;
    while (cpuAck !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h0, cpuAck}, 8'h01);
    chk(cpuRdata, ex);
    chk({7'h0, cpuFault}, {7'h0, refused});
  endtask
  // bank write then plain ram read of the same byte, back to back
  task alias_b2b(input logic [3:0] bs, input logic [2:0] rs,
      input logic [7:0] wd);
    logic [19:0] ea;
    ea = BANK_FIRST + {13'h0, bs, rs};
    shadow[ea] = wd;
    @(negedge clk_sys);
    {cpuReq, cpuFetch, cpuWrite, cpuBank} = 4'b1011;
    {cpuBankSel, cpuRegSel, cpuWdata} = {bs, rs, wd};
    @(negedge clk_sys);
    chk({7'h0, cpuAck}, 8'h01);
    {cpuWrite, cpuBank, cpuAddr} = {1'b0, 1'b0, ea};
    @(negedge clk_sys);
    cpuReq = 1'b0;
    chk({7'h0, cpuAck}, 8'h01);
    chk(cpuRdata, wd);
  endtask
  initial begin
    int k;
    logic [31:0] r;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    // fill all of RAM so no read sees undefined bytes
    for (int i = 0; i < RAM_BYTES; i++) begin
      op(0, 1, 0, 0, 0, RAM_FIRST + 20'(i), 8'($random(seed)));
    end
    op(1, 0, 0, 0, 0, 20'h00000, 0);
    op(1, 0, 0, 0, 0, 20'h00fff, 0);
    op(1, 0, 0, 0, 0, 20'h01000, 0);
    op(1, 0, 0, 0, 0, 20'hfffff, 0);
    op(0, 1, 1, 4'hf, 3'h7, 0, 8'h5a);
    alias_b2b(4'h0, 3'h0, 8'hc3);
    op(0, 0, 0, 0, 0, BANK_LAST, 0);
    op(0, 1, 0, 0, 0, 20'h00240, 8'ha5);
    op(0, 0, 0, 0, 0, 20'h00240, 0);
    op(0, 1, 0, 0, 0, PER_LAST, 8'h3c);
    op(0, 0, 0, 0, 0, PER_LAST, 0);
    for (int i = 0; i < 600; i++) begin
      k = {$random(seed)} % 7;
      r = $random(seed);
      case (k)
        0: op(0, r[20], 0, 0, 0, RAM_FIRST + {11'h0, r[8:0]},
            r[31:24]);
        1: op(0, r[20], 1, r[3:0], r[6:4], r[19:0], r[31:24]);
        2: op(1, 0, 0, 0, 0, {8'h0, r[11:0]}, 0);
        3: op(1, 0, 0, 0, 0, r[19:0] | 20'h01000, 0);
        4: op(0, r[20], 0, 0, 0, r[19:0] % 20'hffdc0 + 20'h00240,
            r[31:24]);
        6: alias_b2b(r[3:0], r[6:4], r[31:24]);
        default: op(0, r[20], 0, 0, 0, {14'h0, r[5:0]}, r[31:24]);
      endcase
    end
    report_and_stop;
  end
  initial begin
    #400000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
